/* File: src/cpe_cfg.svh */
// constants for the codec power enable and start sync block
// How it works
// - bit-clock outputs stop when their own enable bits are zero.
// - conversion-clock outputs stop when their own enable bits are zero.
// - each clock generator powers down when its enable bit is zero.
// - left and right ADC channels power down separately on a zero enable.
// - each DAC pair powers down when its enable bit is zero.
// - register 27 holds eight enables; each zero powers its resource down.
// - converter power-down bit set to one powers all sections and channels down; clock enables stay.
// - rate changes on enabled resources apply at once, no resync wait.
// - gain, mute and attenuation changes are accepted at any time.
// - DAC pair starts at first conversion edge after sixth frame sync.
// - the six-frame wait lets the four-entry DAC FIFO fill.
// - ADC channel starts at first conversion edge after sixth frame sync.
// - stale ADC data is flushed during the six-frame wait.
`ifndef CPE_CFG_SVH
`define CPE_CFG_SVH
`define CPE_ADDR_MAIN 12'h06c
`define CPE_ADDR_CLK 12'h070
`define CPE_ADDR_CONVERSION_CLOCK 12'h074
`define CPE_ADDR_STAT 12'h078
`define CPE_ADDR_RATE 12'h07c
`define CPE_ADDR_GAIN 12'h080
`define CPE_MAIN_RESET 32'h0000_0000
`define CPE_CLK_RESET 32'h0000_0000
`define CPE_CONVERSION_CLOCK_RESET 32'h0000_0000
`define CPE_RATE_RESET 32'h0000_0000
`define CPE_GAIN_RESET 32'h0000_0000
`define CPE_MAIN_HP 0
`define CPE_MAIN_DDM 1
`define CPE_MAIN_AAM 2
`define CPE_MAIN_ADL 3
`define CPE_MAIN_ADR 4
`define CPE_MAIN_DA2 5
`define CPE_MAIN_DA1 6
`define CPE_MAIN_ANA 7
`define CPE_CLK_OUT 0
`define CPE_CLK_BT 1
`define CPE_CLK_CV 4
`define CPE_CLK_GEN 7
`define CPE_CONVERSION_CLOCK_PDN 0
`define CPE_FS_WAIT 3'h6
`define CPE_DAC_FIFO_DEPTH 4
`endif

/* File: src/cpe_pkg.sv */
// types for the codec power enable and start sync block
package cpe_pkg;
  typedef enum logic [1:0] {
    CPE_OFF = 2'b00,
    CPE_WAIT_FS = 2'b01,
    CPE_WAIT_CV = 2'b11,
    CPE_RUN = 2'b10
  } cpe_state_t;
  typedef struct packed {
    logic headphone_enable;
    logic dac_to_dac_mix_enable;
    logic analog_mix_enable;
    logic analog_section_enable;
    logic converter_powerdown;
  } cpe_power_t;
  typedef struct packed {
    logic [2:0] bit_clock_enable;
    logic [2:0] conversion_clock_clock_enable;
    logic [2:0] clock_gen_enable;
    logic clock_out_enable;
  } cpe_clocks_t;
endpackage

/* File: src/cpe_chan_start.sv */
// start gate for one conversion channel: six frame syncs then a conversion edge
`timescale 1ns/1ps
`include "cpe_cfg.svh"
module cpe_chan_start
  import cpe_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic enable,
  input wire logic fs_rise,
  input wire logic cv_rise,
  // status
  output logic running,
  output logic flushing
);
  cpe_state_t state_reg;
  logic [2:0] fs_count_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= CPE_OFF;
      fs_count_reg <= 3'h0;
    end else if (!enable) begin
      state_reg <= CPE_OFF;
      fs_count_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        CPE_OFF: begin
          state_reg <= CPE_WAIT_FS;
          fs_count_reg <= 3'h0;
        end
        CPE_WAIT_FS: begin
          if (fs_rise) begin
            fs_count_reg <= fs_count_reg + 3'h1;
            if (fs_count_reg == `CPE_FS_WAIT - 3'h1) begin
              state_reg <= CPE_WAIT_CV;
            end
          end
        end
        CPE_WAIT_CV: begin
          if (cv_rise) begin
            state_reg <= CPE_RUN;
          end
        end
        CPE_RUN: begin
          state_reg <= CPE_RUN;
        end
      endcase
    end
  end

  assign running = (state_reg == CPE_RUN);
  // wait window used to fill or flush
  assign flushing = (state_reg == CPE_WAIT_FS) || (state_reg == CPE_WAIT_CV);
endmodule

/* File: src/cpe_top.sv */
// codec power enables, clock gating and channel start synchronisation
`timescale 1ns/1ps
`include "cpe_cfg.svh"
module cpe_top
  import cpe_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // timing pins
  input wire logic SERIAL_FRAME_SYNC,
  input wire logic CONVERSION_CLOCK,
  // power controls
  output cpe_power_t POWER,
  output cpe_clocks_t CLOCKS,
  output logic [1:0] ADC_POWER,
  output logic [1:0] DAC_POWER,
  // channel start
  output logic [1:0] ADC_RUN,
  output logic [1:0] DAC_RUN,
  output logic [1:0] ADC_FLUSH,
  output logic [1:0] DAC_FILL,
  // on-the-fly settings
  output logic [31:0] RATE_SETTING,
  output logic [31:0] GAIN_SETTING
);
  logic [31:0] main_reg;
  logic [31:0] clk_reg;
  logic [31:0] conversion_clock_reg;
  logic [31:0] rate_reg;
  logic [31:0] gain_reg;
  logic [31:0] rdata_next;
  logic [31:0] wdata_mask;
  logic known;
  logic wr_fire;
  logic rd_fire;
  logic [2:0] fs_sync_reg;
  logic [2:0] cv_sync_reg;
  logic fs_rise;
  logic cv_rise;
  logic [3:0] chan_en;
  logic [3:0] chan_run;
  logic [3:0] chan_flush;

  assign wr_fire = PSEL && PENABLE && PWRITE;
  assign rd_fire = PSEL && PENABLE && !PWRITE;
  assign wdata_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};

  always_comb begin
    known = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (PADDR)
      `CPE_ADDR_MAIN: rdata_next = {24'h00_0000, main_reg[7:0]};
      `CPE_ADDR_CLK: rdata_next = {22'h0, clk_reg[9:0]};
      `CPE_ADDR_CONVERSION_CLOCK: rdata_next = {31'h0, conversion_clock_reg[0]};
      `CPE_ADDR_STAT: rdata_next = {24'h00_0000, DAC_RUN, ADC_RUN, DAC_FILL, ADC_FLUSH};
      `CPE_ADDR_RATE: rdata_next = rate_reg;
      `CPE_ADDR_GAIN: rdata_next = gain_reg;
      default: known = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      main_reg <= `CPE_MAIN_RESET;
    end else if (wr_fire && PADDR == `CPE_ADDR_MAIN) begin
      main_reg <= (main_reg & ~wdata_mask) | (PWDATA & wdata_mask & 32'h0000_00ff);
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_reg <= `CPE_CLK_RESET;
    end else if (wr_fire && PADDR == `CPE_ADDR_CLK) begin
      clk_reg <= (clk_reg & ~wdata_mask) | (PWDATA & wdata_mask & 32'h0000_03ff);
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      conversion_clock_reg <= `CPE_CONVERSION_CLOCK_RESET;
    end else if (wr_fire && PADDR == `CPE_ADDR_CONVERSION_CLOCK) begin
      conversion_clock_reg <= (conversion_clock_reg & ~wdata_mask) | (PWDATA & wdata_mask & 32'h0000_0001);
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rate_reg <= `CPE_RATE_RESET;
      gain_reg <= `CPE_GAIN_RESET;
    end else if (wr_fire) begin
      if (PADDR == `CPE_ADDR_RATE) begin
        rate_reg <= (rate_reg & ~wdata_mask) | (PWDATA & wdata_mask);
      end
      if (PADDR == `CPE_ADDR_GAIN) begin
        gain_reg <= (gain_reg & ~wdata_mask) | (PWDATA & wdata_mask);
      end
    end
  end

  // zero-wait slave: answer in the access cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !known;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= rdata_next;
      end
    end
  end

  // pins cross in by two flops, third stage for edge detect
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fs_sync_reg <= 3'h0;
      cv_sync_reg <= 3'h0;
    end else begin
      fs_sync_reg <= {fs_sync_reg[1:0], SERIAL_FRAME_SYNC};
      cv_sync_reg <= {cv_sync_reg[1:0], CONVERSION_CLOCK};
    end
  end
  assign fs_rise = fs_sync_reg[1] && !fs_sync_reg[2];
  assign cv_rise = cv_sync_reg[1] && !cv_sync_reg[2];

  // channels also fall with converter power-down
  assign chan_en = {main_reg[`CPE_MAIN_DA2], main_reg[`CPE_MAIN_DA1],
                    main_reg[`CPE_MAIN_ADR], main_reg[`CPE_MAIN_ADL]} & {4{!conversion_clock_reg[`CPE_CONVERSION_CLOCK_PDN]}};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      cpe_chan_start u_start (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .enable(chan_en[g]),
        .fs_rise(fs_rise),
        .cv_rise(cv_rise),
        .running(chan_run[g]),
        .flushing(chan_flush[g])
      );
    end
  endgenerate

  // registered power levels; powerdown overrides every section enable
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      POWER <= '0;
    end else begin
      POWER.headphone_enable <= main_reg[`CPE_MAIN_HP] && !conversion_clock_reg[`CPE_CONVERSION_CLOCK_PDN];
      POWER.dac_to_dac_mix_enable <= main_reg[`CPE_MAIN_DDM] && !conversion_clock_reg[`CPE_CONVERSION_CLOCK_PDN];
      POWER.analog_mix_enable <= main_reg[`CPE_MAIN_AAM] && !conversion_clock_reg[`CPE_CONVERSION_CLOCK_PDN];
      POWER.analog_section_enable <= main_reg[`CPE_MAIN_ANA] && !conversion_clock_reg[`CPE_CONVERSION_CLOCK_PDN];
      POWER.converter_powerdown <= conversion_clock_reg[`CPE_CONVERSION_CLOCK_PDN];
    end
  end

  // clock enables are levels for the clock block, not gated clocks
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      CLOCKS <= '0;
    end else begin
      CLOCKS.clock_out_enable <= clk_reg[`CPE_CLK_OUT];
      CLOCKS.bit_clock_enable <= clk_reg[`CPE_CLK_BT +: 3];
      CLOCKS.conversion_clock_clock_enable <= clk_reg[`CPE_CLK_CV +: 3];
      CLOCKS.clock_gen_enable <= clk_reg[`CPE_CLK_GEN +: 3];
    end
  end

  // channel power follows the gated channel enables
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ADC_POWER <= 2'h0;
      DAC_POWER <= 2'h0;
    end else begin
      ADC_POWER <= chan_en[1:0];
      DAC_POWER <= chan_en[3:2];
    end
  end

  // channel start status, one cycle behind the start gates
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ADC_RUN <= 2'h0;
      DAC_RUN <= 2'h0;
      ADC_FLUSH <= 2'h0;
      DAC_FILL <= 2'h0;
    end else begin
      ADC_RUN <= chan_run[1:0];
      DAC_RUN <= chan_run[3:2];
      ADC_FLUSH <= chan_flush[1:0];
      DAC_FILL <= chan_flush[3:2];
    end
  end

  // settings copies: no resync wait, so a plain register stage
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RATE_SETTING <= 32'h0000_0000;
      GAIN_SETTING <= 32'h0000_0000;
    end else begin
      RATE_SETTING <= rate_reg;
      GAIN_SETTING <= gain_reg;
    end
  end
endmodule

/* File: testbench/cpe_top_monitor.sv */
// checker for power enables and channel start
`timescale 1ns/1ps
module cpe_top_monitor
  import cpe_pkg::*;
(
  // bus
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  // power and start
  input wire cpe_power_t POWER,
  input wire logic [1:0] ADC_POWER,
  input wire logic [1:0] DAC_POWER,
  input wire logic [1:0] ADC_RUN,
  input wire logic [1:0] DAC_RUN,
  input wire logic [1:0] ADC_FLUSH,
  input wire logic [1:0] DAC_FILL,
  input wire logic [31:0] RATE_SETTING
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  a_ready_zero_wait: assert property (PSEL && PENABLE |-> PREADY) else $error("no ready");
  a_pdn_all_off: assert property (POWER.converter_powerdown |-> POWER[4:1] == 4'h0 &&
    (ADC_POWER | DAC_POWER) == 2'b00) else $error("powerdown leak");
  a_rate_on_fly: assert property (PSEL && PENABLE && PWRITE && PADDR == 12'h07c && PSTRB == 4'hf
    |-> ##2 RATE_SETTING == $past(PWDATA, 2)) else $error("rate late");
  a_fill_not_run: assert property ((DAC_FILL & DAC_RUN) == 2'b00) else $error("fill and run");
  a_flush_not_run: assert property ((ADC_FLUSH & ADC_RUN) == 2'b00) else $error("flush and run");
  a_dac_start_wait: assert property ($rose(DAC_RUN[0]) |-> $past(DAC_FILL[0])) else $error("dac early");
  a_adc_start_wait: assert property ($rose(ADC_RUN[1]) |-> $past(ADC_FLUSH[1])) else $error("adc early");
  a_dac_off_stop: assert property (DAC_RUN[1] && !DAC_POWER[1] |-> ##[1:2] !DAC_RUN[1])
    else $error("dac runs off");
endmodule
bind cpe_top cpe_top_monitor u_cpe_top_monitor (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
  .POWER(POWER), .ADC_POWER(ADC_POWER), .DAC_POWER(DAC_POWER), .ADC_RUN(ADC_RUN), .DAC_RUN(DAC_RUN),
  .ADC_FLUSH(ADC_FLUSH), .DAC_FILL(DAC_FILL), .RATE_SETTING(RATE_SETTING));

/* File: testbench/cpe_host_model.sv */
// host model driving the frame sync and conversion clock pins
`timescale 1ns/1ps
module cpe_host_model (
  // control
  input wire logic clk,
  input wire logic go,
  // timing pins
  output logic fs,
  output logic cv
);
  logic [5:0] cnt_reg = 6'h00;
  logic [2:0] cv_reg = 3'h0;
  // frames run from the enable onward
  always @(posedge clk) begin
    cnt_reg <= (go && cnt_reg != 6'h27) ? cnt_reg + 6'h01 : 6'h00;
    cv_reg <= cv_reg + 3'h1;
  end
  // one frame source for every channel
  assign fs = go && cnt_reg >= 6'h0a && cnt_reg < 6'h0e;
  assign cv = cv_reg[2];
endmodule

/* File: testbench/cpe_top_tb.sv */
// bench for the power enable and start sync block
`timescale 1ns/1ps
`include "cpe_cfg.svh"
module cpe_top_tb
  import cpe_pkg::*;
;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, fs, fs_d, cv, go, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, rate, gain, r;
  logic [3:0] pstrb;
  cpe_power_t power;
  cpe_clocks_t clocks;
  logic [1:0] adc_pwr, dac_pwr, adc_run, dac_run, adc_flush, dac_fill;
  int fails, check_count, n, k;
  cpe_top u_cpe_top (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SERIAL_FRAME_SYNC(fs), .CONVERSION_CLOCK(cv), .POWER(power), .CLOCKS(clocks), .ADC_POWER(adc_pwr),
    .DAC_POWER(dac_pwr), .ADC_RUN(adc_run), .DAC_RUN(dac_run), .ADC_FLUSH(adc_flush), .DAC_FILL(dac_fill),
    .RATE_SETTING(rate), .GAIN_SETTING(gain));
  cpe_host_model u_cpe_host_model (.clk(clock), .go(go), .fs(fs), .cv(cv));
  task automatic summarize();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one transfer, then three idle edges so the next call never reassigns in the same step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      w++;
    end while (pready !== 1'b1 && w < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w >= 20) fails++;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    go = 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'h06c + 12'(4 * i), 32'h0);
      cmp("reset", 32'h0, rdat);
    end
    apb(1'b0, 12'h084, 32'h0);
    cmp("slverr", 32'h1, {31'h0, rerr});
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `CPE_ADDR_MAIN, 32'h1 << i);
      cmp("main", 32'h1 << i, {24'h0, power.analog_section_enable, dac_pwr[0], dac_pwr[1], adc_pwr,
        power.analog_mix_enable, power.dac_to_dac_mix_enable, power.headphone_enable});
    end
    for (int i = 0; i < 10; i++) begin
      r = 32'h1 << i;
      apb(1'b1, `CPE_ADDR_CLK, r);
      cmp("clocks", {22'h0, r[3:1], r[6:4], r[9:7], r[0]}, {22'h0, clocks});
    end
    apb(1'b1, `CPE_ADDR_MAIN, 32'hff);
    apb(1'b1, `CPE_ADDR_CONVERSION_CLOCK, 32'h1);
    cmp("pdn", 32'h10, {23'h0, power, dac_pwr, adc_pwr});
    apb(1'b1, `CPE_ADDR_CONVERSION_CLOCK, 32'h0);
    apb(1'b1, `CPE_ADDR_MAIN, 32'h0);
    apb(1'b1, `CPE_ADDR_MAIN, 32'h78);
    apb(1'b0, `CPE_ADDR_MAIN, 32'h0);
    cmp("main read", 32'h78, rdat);
    go <= 1'b1;
    n = 0;
    k = 0;
    fs_d = fs;
    while (dac_run !== 2'b11 && n < 1000) begin
      @(posedge clock);
      n++;
      if (fs === 1'b1 && fs_d === 1'b0) k++;
      fs_d = fs;
      if (k == 3) cmp("wait", 32'hf, {28'h0, adc_flush, dac_fill});
    end
    if (n >= 1000) fails++;
    cmp("frames", 32'h6, k);
    cmp("adc run", 32'h3, {30'h0, adc_run});
    apb(1'b1, `CPE_ADDR_RATE, 32'h0000ac44);
    apb(1'b1, `CPE_ADDR_GAIN, 32'h0000_5a3c);
    apb(1'b0, `CPE_ADDR_STAT, 32'h0);
    cmp("status", 32'hf0, rdat);
    cmp("rate", 32'hac44, rate);
    cmp("gain", 32'h5a3c, gain);
    // channels powered down before any clock enable change
    apb(1'b1, `CPE_ADDR_MAIN, 32'h0);
    cmp("stop", 32'h0, {28'h0, dac_run, adc_run});
    apb(1'b1, `CPE_ADDR_CLK, 32'h3ff);
    apb(1'b0, `CPE_ADDR_CLK, 32'h0);
    cmp("clk read", 32'h3ff, rdat);
    // mid-run reset clears registers and outputs at once
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    cmp("reset clocks", 32'h0, {22'h0, clocks});
    cmp("reset rate", 32'h0, rate);
    arst_n <= 1'b1;
    apb(1'b0, `CPE_ADDR_CLK, 32'h0);
    cmp("clk after", 32'h0, rdat);
    summarize();
  end
endmodule
